// file: gate_cmd_ctrl.sv
// Controller driving a three-phase gate driver's command and fault pins
// Contract
// - Gate commands are active high, high meaning transistor on.
// - Both commands of a phase stay low at least 1.5 us between one side off and the other on.
// - Every high and low phase of a command lasts at least 0.5 us. A kill ends a pulse at once, before its timer.
// - The carrier frequency stays at or below 20 kHz.
// - Command lines are always actively driven, never floating.
// - The shared fault line reports driver faults and also accepts shutdown requests.
// - A low fault line stops all gate pulses at once, with no automatic continuation.
// - All commands go low within 5 ms of the fault line going low.
// - After a fault stop, commands resume only after at least 2 s.
// - A shutdown request holds the line low at least 3 us, and high at least 3 us between.
`timescale 1ns/1ns
module gate_cmd_ctrl
  import gate_cmd_pkg::*;
#(
  parameter int unsigned PHASES  = NUM_PHASES,
  parameter int unsigned PERIOD  = PERIOD_CYC,
  parameter int unsigned RESTART = RESTART_CYC,
  parameter int unsigned HOLD    = HOLD_CYC,
  parameter int unsigned SHDN    = SHDN_CYC
)
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  // User control
  input  wire logic                    run_en,
  input  wire logic                    shutdown_req,
  input  wire logic                    fault_ack,
  input  wire logic [PHASES*DUTY_W-1:0] duty,
  // Gate commands
  output phase_cmd_t [PHASES-1:0]      gate_cmd,
  // Shared fault line
  input  wire logic                    fault_line_in,
  output logic                         fault_line_out,
  output logic                         fault_line_oe,
  // Status
  output logic                         running,
  output logic                         fault_latched,
  output logic                         restart_wait
);

  // ****************************************
  // Carrier
  // ****************************************
  ctrl_state_t      state_ff;
  logic [CNT_W-1:0] carrier_ff;
  logic [CNT_W-1:0] wait_ff;
  logic [CNT_W-1:0] shdn_ff;
  logic             kill;
  logic             line_low;
  logic [CNT_W-1:0] gap_ff;
  logic             shdn_go;

  function automatic logic [CNT_W-1:0] duty_cycles(input logic [DUTY_W-1:0] d);
    logic [CNT_W+DUTY_W-1:0] prod;
    prod = {{CNT_W{1'b0}}, d} * (CNT_W+DUTY_W)'(PERIOD);
    duty_cycles = prod[CNT_W+DUTY_W-1:DUTY_W];
  endfunction

  assign line_low = !fault_line_in;
  assign kill     = (state_ff != ST_RUN) || line_low;
  // Requests outside run or inside the rest gap are dropped
  assign shdn_go  = (state_ff == ST_RUN) && !line_low && shutdown_req && (gap_ff == '0);

  // Fixed period, so the carrier never exceeds its ceiling
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      carrier_ff <= '0;
    else if (carrier_ff >= CNT_W'(PERIOD - 1))
      carrier_ff <= '0;
    else
      carrier_ff <= carrier_ff + 1'b1;
  end

  // ****************************************
  // Phase legs
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < PHASES; g++)
    begin : leg
      logic want_high;
      assign want_high = carrier_ff < duty_cycles(duty[g*DUTY_W +: DUTY_W]);
      phase_leg u_leg (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .kill      (kill),
        .want_high (want_high),
        .want_low  (!want_high),
        .cmd       (gate_cmd[g])
      );
    end
  endgenerate

  // ****************************************
  // Supervision
  // ****************************************
  // Kill acts in cycles, far inside the hold window
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      state_ff <= ST_RESET;
    else
    begin
      case (state_ff)
        ST_RESET:
        begin
          if (line_low)
            state_ff <= ST_STOP;
          else if (run_en)
            state_ff <= ST_RUN;
        end
        ST_RUN:
        begin
          if (line_low)
            state_ff <= ST_STOP;
          else if (shdn_go)
            state_ff <= ST_SHDN;
          else if (!run_en)
            state_ff <= ST_RESET;
        end
        ST_SHDN:
        begin
          if (shdn_ff == '0)
            state_ff <= ST_STOP;
        end
        ST_STOP:
        begin
          if (!line_low && fault_ack)
            state_ff <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (line_low)
            state_ff <= ST_STOP;
          else if (wait_ff == '0)
            state_ff <= ST_RESET;
        end
        default:
          state_ff <= ST_RESET;
      endcase
    end
  end

  // ****************************************
  // Restart wait
  // ****************************************
  // Reloaded on every stop cycle, so the wait always runs in full
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      wait_ff <= '0;
    else if (state_ff == ST_STOP)
      wait_ff <= CNT_W'(RESTART);
    else if (state_ff == ST_WAIT && !line_low && wait_ff != '0)
      wait_ff <= wait_ff - 1'b1;
  end

  // ****************************************
  // Shared fault line
  // ****************************************
  // Own pulls leave the line high at least as long before the next one
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      gap_ff <= '0;
    else if (fault_line_oe)
      gap_ff <= CNT_W'(SHDN);
    else if (gap_ff != '0)
      gap_ff <= gap_ff - 1'b1;
  end

  // Shutdown pulse low then enforced high gap
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shdn_ff        <= '0;
      fault_line_out <= 1'b0;
      fault_line_oe  <= 1'b0;
    end
    else
    begin
      fault_line_out <= 1'b0;
      if (shdn_go)
      begin
        shdn_ff       <= CNT_W'(SHDN);
        fault_line_oe <= 1'b1;
      end
      else if (shdn_ff != '0)
        shdn_ff <= shdn_ff - 1'b1;
      else
        fault_line_oe <= 1'b0;
    end
  end

  // ****************************************
  // Status
  // ****************************************
  // Status flags
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      running       <= 1'b0;
      fault_latched <= 1'b0;
      restart_wait  <= 1'b0;
    end
    else
    begin
      running       <= (state_ff == ST_RUN) && !line_low;
      fault_latched <= (state_ff == ST_STOP) || (state_ff == ST_SHDN) || line_low;
      restart_wait  <= (state_ff == ST_WAIT);
    end
  end

endmodule

// file: gate_cmd_pkg.sv
// Package of constants and types for the three-phase gate command controller
package gate_cmd_pkg;

  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned NUM_PHASES    = 3;
  localparam int unsigned DEAD_TIME_NS  = 1500;
  localparam int unsigned MIN_PULSE_NS  = 500;
  localparam int unsigned MAX_CARRIER_HZ = 20000;
  localparam int unsigned HOLD_TIME_MS  = 5;
  localparam int unsigned RESTART_S     = 2;
  localparam int unsigned SHDN_MIN_NS   = 3000;

  localparam int unsigned DEAD_CYC   = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_CYC  = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PERIOD_CYC = (CLK_MHZ * 1000000 + MAX_CARRIER_HZ - 1) / MAX_CARRIER_HZ;
  localparam int unsigned HOLD_CYC   = HOLD_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned RESTART_CYC = RESTART_S * CLK_MHZ * 1000000;
  localparam int unsigned SHDN_CYC   = (SHDN_MIN_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned DUTY_W = 16;
  localparam int unsigned CNT_W  = 32;

  typedef struct packed {
    logic high_side_cmd;
    logic low_side_cmd;
  } phase_cmd_t;

  typedef enum logic [1:0] {
    SIDE_OFF,
    SIDE_HIGH,
    SIDE_LOW
  } side_t;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_RUN,
    ST_STOP,
    ST_SHDN,
    ST_WAIT
  } ctrl_state_t;

endpackage

// file: phase_leg.sv
// One phase leg: dead time and minimum pulse enforcement for a pair of commands
`timescale 1ns/1ns
module phase_leg
  import gate_cmd_pkg::*;
#(
  parameter int unsigned DEAD  = DEAD_CYC,
  parameter int unsigned PULSE = PULSE_CYC
)
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       kill,
  input  wire logic       want_high,
  input  wire logic       want_low,
  // Gate commands
  output phase_cmd_t      cmd
);

  side_t            side_ff;
  logic [CNT_W-1:0] hold_ff;
  side_t            nxt_side;
  logic             pending;

  // Requested side; both asked means off, never both on
  always_comb
  begin
    nxt_side = SIDE_OFF;
    if (!kill && want_high && !want_low)
      nxt_side = SIDE_HIGH;
    else if (!kill && want_low && !want_high)
      nxt_side = SIDE_LOW;
  end

  assign pending = (nxt_side != side_ff);

  // Kill bypasses the pulse timer; a short final pulse beats a late stop
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      side_ff <= SIDE_OFF;
      hold_ff <= '0;
    end
    else if (kill && side_ff != SIDE_OFF)
    begin
      side_ff <= SIDE_OFF;
      hold_ff <= CNT_W'(DEAD);
    end
    else if (hold_ff != '0)
      hold_ff <= hold_ff - 1'b1;
    else if (pending && side_ff != SIDE_OFF)
    begin
      side_ff <= SIDE_OFF;
      hold_ff <= CNT_W'(DEAD > PULSE ? DEAD : PULSE);
    end
    else if (pending)
    begin
      side_ff <= nxt_side;
      hold_ff <= CNT_W'(PULSE);
    end
  end

  // Always driven, never tristated
  // Follows the held side gated by kill, so only a kill ends a pulse before its timer
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cmd <= '0;
    else
    begin
      cmd.high_side_cmd <= (side_ff == SIDE_HIGH) && !kill;
      cmd.low_side_cmd  <= (side_ff == SIDE_LOW) && !kill;
    end
  end

endmodule

// file: gate_cmd_sva.sv
// Port assertions for the gate command controller
`timescale 1ns/1ns
module gate_cmd_sva
  import gate_cmd_pkg::*;
#(
  parameter int unsigned PHASES = NUM_PHASES,
  parameter int unsigned SHDN   = SHDN_CYC
)
(
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  // Watched ports
  input wire logic                   shutdown_req,
  input wire phase_cmd_t [PHASES-1:0] gate_cmd,
  input wire logic                   fault_line_in,
  input wire logic                   fault_line_out,
  input wire logic                   fault_line_oe,
  input wire logic                   running,
  input wire logic                   fault_latched,
  input wire logic                   restart_wait
);
  // ****
  // Helper counters
  // ****
  logic [7:0]  idle_ff;
  logic [15:0] oe_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Starts saturated so the first turn-on after reset is legal
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) idle_ff <= 8'(DEAD_CYC);
    else if (gate_cmd[0] != 2'h0) idle_ff <= 8'h00;
    else if (idle_ff != 8'(DEAD_CYC)) idle_ff <= idle_ff + 8'h01;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) oe_ff <= 16'h0000;
    else oe_ff <= fault_line_oe ? oe_ff + 16'h0001 : 16'h0000;
  both_off_a: assert property (gate_cmd[0] != 2'h3 && gate_cmd[1] != 2'h3
    && gate_cmd[2] != 2'h3) else $error("both sides on");
  dead_gap_a: assert property ($rose(gate_cmd[0] != 2'h0) |-> idle_ff == 8'(DEAD_CYC))
    else $error("dead time short");
  min_pulse_a: assert property ($fell(gate_cmd[0].high_side_cmd) && fault_line_in
    |-> $past(gate_cmd[0].high_side_cmd, 63)) else $error("pulse short");
  fault_kill_a: assert property (!fault_line_in |=> gate_cmd == '0)
    else $error("no stop on fault");
  stop_hold_a: assert property (fault_latched |=> gate_cmd == '0)
    else $error("commands during stop");
  wait_quiet_a: assert property (restart_wait |-> gate_cmd == '0)
    else $error("commands during wait");
  drain_only_a: assert property (fault_line_out == 1'b0)
    else $error("line driven high");
  shdn_start_a: assert property (running && shutdown_req |=> fault_line_oe)
    else $error("shutdown not pulled");
  shdn_len_a: assert property ($fell(fault_line_oe) |-> oe_ff == 16'(SHDN + 1))
    else $error("shutdown length");
endmodule
bind gate_cmd_ctrl gate_cmd_sva #(.PHASES(PHASES), .SHDN(SHDN)) i_sva (.ref_clk, .nrst,
  .shutdown_req, .gate_cmd, .fault_line_in, .fault_line_out, .fault_line_oe, .running,
  .fault_latched, .restart_wait);

// file: gate_driver_model.sv
// Behavioural model of the three-phase gate driver
`timescale 1ns/1ns
module gate_driver_model
  import gate_cmd_pkg::*;
(
  // Controller side and injected driver fault
  input wire phase_cmd_t [NUM_PHASES-1:0] cmd,
  input wire logic                       ctrl_pull,
  input wire logic                       fault_pull,
  // Wired line and switch states
  output logic                           fault_line,
  output logic [2*NUM_PHASES-1:0]        switch_on
);
  // Open drain on both sides, pull-up restores high
  assign fault_line = (ctrl_pull || fault_pull) ? 1'b0 : 1'b1;
  // Unknown or floating input counts as off
  always_comb
    for (int i = 0; i < 2 * NUM_PHASES; i++)
      switch_on[i] = fault_line && (cmd[i/2][i%2] === 1'b1);
endmodule

// file: gate_cmd_ctrl_bench.sv
// Self-checking bench for the gate command controller
`timescale 1ns/1ns
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t %s", $time, m); end end
module gate_cmd_ctrl_bench
  import gate_cmd_pkg::*;
;
  localparam int unsigned PER = PERIOD_CYC;
  localparam int unsigned RST = 2000;
  localparam int unsigned SHD = 10;
  int bad_count = 0;
  int n_checks = 0;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic run_en = 1'b0;
  logic shutdown_req = 1'b0;
  logic fault_ack = 1'b0;
  logic fault_pull = 1'b0;
  logic [47:0] duty = {16'h4000, 16'hc000, 16'h8000};
  phase_cmd_t [2:0] gate_cmd;
  logic line, l_out, l_oe, running, fault_latched, restart_wait;
  logic [5:0] sw;
  always #4 ref_clk = ~ref_clk;
  gate_cmd_ctrl #(.PERIOD(PER), .RESTART(RST), .SHDN(SHD)) i_dut (.ref_clk(ref_clk),
    .nrst(nrst), .run_en(run_en), .shutdown_req(shutdown_req), .fault_ack(fault_ack),
    .duty(duty), .gate_cmd(gate_cmd), .fault_line_in(line), .fault_line_out(l_out),
    .fault_line_oe(l_oe), .running(running), .fault_latched(fault_latched),
    .restart_wait(restart_wait));
  gate_driver_model i_dev (.cmd(gate_cmd), .ctrl_pull(l_oe), .fault_pull(fault_pull),
    .fault_line(line), .switch_on(sw));
  // ****
  // Tasks
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic next_rise(output int c);
    logic p;
    c = 0;
    p = gate_cmd[0].high_side_cmd;
    while (c < 2 * PER && !(gate_cmd[0].high_side_cmd === 1'b1 && p === 1'b0))
    begin
      p = gate_cmd[0].high_side_cmd;
      tick(1);
      c++;
    end
  endtask
  task automatic t_run;
    int c;
    `CHK(gate_cmd, 6'h00, "not quiet after reset")
    run_en = 1'b1;
    tick(PER);
    next_rise(c);
    `CHK(sw[1], 1'b1, "high side not on")
    next_rise(c);
    `CHK(c, PER, "carrier period")
    $display("t_run done");
  endtask
  // Restart only counts from the ack, so the wait is timed from here
  task automatic t_restart;
    int c;
    fault_ack = 1'b1;
    tick(2);
    fault_ack = 1'b0;
    `CHK(restart_wait, 1'b1, "no restart wait")
    tick(RST - 20);
    `CHK(gate_cmd, 6'h00, "early restart")
    c = 0;
    while (running !== 1'b1 && c < PER)
    begin
      tick(1);
      c++;
    end
    `CHK(running, 1'b1, "no restart")
    `CHK(c >= 19, 1'b1, "restart too soon")
  endtask
  task automatic t_fault;
    fault_pull = 1'b1;
    tick(2);
    `CHK(gate_cmd, 6'h00, "no kill")
    `CHK(sw, 6'h00, "switch on in fault")
    fault_ack = 1'b1;
    tick(5);
    `CHK(restart_wait, 1'b0, "ack taken while low")
    fault_pull = 1'b0;
    fault_ack = 1'b0;
    tick(20);
    `CHK(gate_cmd, 6'h00, "auto continue")
    `CHK(fault_latched, 1'b1, "fault not held")
    t_restart;
    $display("t_fault done");
  endtask
  task automatic t_shdn;
    tick(PER / 2);
    shutdown_req = 1'b1;
    tick(1);
    shutdown_req = 1'b0;
    `CHK(line, 1'b0, "line not pulled")
    tick(3);
    `CHK(gate_cmd, 6'h00, "no stop on own pull")
    tick(SHD - 4);
    `CHK(l_oe, 1'b1, "pull too short")
    tick(4);
    `CHK(l_oe, 1'b0, "pull too long")
    `CHK(l_out, 1'b0, "line driven high")
    t_restart;
    $display("t_shdn done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    tick(12);
    nrst = 1'b1;
    t_run;
    t_fault;
    t_shdn;
    tally_and_finish;
  end
  initial
  begin
    tick(40000);
    bad_count++;
    $display("[FAIL] %0t watchdog", $time);
    tally_and_finish;
  end
endmodule
